// [rtl/dhp_host_port.sv]
// Purpose: eight-bit host port for configuration and readback
// Assumes: host strobes and buses asynchronous to clk; accumulator and
//          status inputs come from logic on clk
// Notes:   host data bus split into in, out and output enable
`timescale 1ns/1ps
module dhp_host_port (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // host bus pins
   input  wire logic [2:0]  host_addr_select,
   input  wire logic [7:0]  host_data_bus_in,
   output      logic [7:0]  host_data_bus_out,
   output      logic        host_data_bus_oe,
   input  wire logic        host_wr_n,
   input  wire logic        host_rd_n,
   // accumulators from the demodulator core
   input  wire logic [31:0] carrier_lag_acc,
   input  wire logic [31:0] symbol_lag_acc,
   input  wire logic [7:0]  gain_acc,
   input  wire logic [15:0] phase_error_acc,
   input  wire logic [15:0] false_lock_acc,
   input  wire logic [15:0] gain_error_acc,
   // lock detector handshake
   input  wire logic        lock_mode_processor,
   input  wire logic        lock_integ_end,
   output      logic        lock_reload_enable,
   output      logic        lock_init,
   // remaining status bits from the core
   input  wire logic [5:0]  core_status_bits,
   // control register load port
   output      logic        ctrl_load_strobe,
   output      logic [4:0]  ctrl_load_addr,
   output      logic [31:0] ctrl_load_data
);
   // -------------------------------------------------------------------
   // types
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      DHP_LD_RUN     = 2'b00,
      DHP_LD_PENDING = 2'b01,
      DHP_LD_STOPPED = 2'b10
   } dhp_ld_state_t;

   // -------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------
   logic          rst_s1_reg;
   logic          rst_sync_n;
   logic          wr_s1_reg;
   logic          wr_s2_reg;
   logic          wr_prev_reg;
   logic          rd_s1_reg;
   logic          rd_s2_reg;
   logic [2:0]    addr_s1_reg;
   logic [2:0]    addr_s2_reg;
   logic [7:0]    data_s1_reg;
   logic [7:0]    data_s2_reg;
   logic          wr_event;
   logic [31:0]   hold_reg;
   logic [7:0]    waddr_reg;
   logic          waddr_write_reg;
   logic [7:0]    raddr_reg;
   logic          cmd_halt;
   logic          cmd_restart;
   logic          cmd_snapshot;
   logic          cmd_init;
   logic [31:0]   carrier_snap_reg;
   logic [31:0]   symbol_snap_reg;
   logic [7:0]    gain_snap_reg;
   dhp_ld_state_t ld_state_reg;
   dhp_ld_state_t ld_state_next;
   logic          fsm_stop_ready_flag;
   logic          up_stop_ready_flag;
   logic [7:0]    internal_status_bits;
   logic [31:0]   read_word;
   logic [7:0]    read_byte;
   dhp_cfg_if     cfg ();

   // -------------------------------------------------------------------
   // reset release through two flip-flops
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_reg <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_sync_n <= rst_s1_reg;
      end
   end

   // -------------------------------------------------------------------
   // pin synchronisers; strobes idle high so they reset high
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wr_s1_reg   <= 1'b1;
         wr_s2_reg   <= 1'b1;
         rd_s1_reg   <= 1'b1;
         rd_s2_reg   <= 1'b1;
         addr_s1_reg <= 3'h0;
         addr_s2_reg <= 3'h0;
         data_s1_reg <= dhp_pkg::BYTE_RESET;
         data_s2_reg <= dhp_pkg::BYTE_RESET;
      end else begin
         wr_s1_reg   <= host_wr_n;
         wr_s2_reg   <= wr_s1_reg;
         rd_s1_reg   <= host_rd_n;
         rd_s2_reg   <= rd_s1_reg;
         addr_s1_reg <= host_addr_select;
         addr_s2_reg <= addr_s1_reg;
         data_s1_reg <= host_data_bus_in;
         data_s2_reg <= data_s1_reg;
      end
   end

   // -------------------------------------------------------------------
   // write taken at the trailing edge, when bus copies have settled
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wr_prev_reg <= 1'b1;
      end else begin
         wr_prev_reg <= wr_s2_reg;
      end
   end

   assign wr_event = wr_s2_reg && !wr_prev_reg;

   // -------------------------------------------------------------------
   // holding registers, one byte lane per address
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         hold_reg <= dhp_pkg::HOLD_RESET;
      end else if (wr_event) begin
         unique case (addr_s2_reg)
            dhp_pkg::HA_HOLD0: hold_reg[7:0]   <= data_s2_reg;
            dhp_pkg::HA_HOLD1: hold_reg[15:8]  <= data_s2_reg;
            dhp_pkg::HA_HOLD2: hold_reg[23:16] <= data_s2_reg;
            dhp_pkg::HA_HOLD3: hold_reg[31:24] <= data_s2_reg;
            default: hold_reg <= hold_reg;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // write address register; pulse marks each write for the loader
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         waddr_reg       <= dhp_pkg::ADDR_RESET;
         waddr_write_reg <= 1'b0;
      end else begin
         waddr_write_reg <= wr_event && addr_s2_reg == dhp_pkg::HA_WADDR;
         if (wr_event && addr_s2_reg == dhp_pkg::HA_WADDR) begin
            waddr_reg <= data_s2_reg;
         end
      end
   end

   // -------------------------------------------------------------------
   // read address register
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         raddr_reg <= dhp_pkg::ADDR_RESET;
      end else if (wr_event && addr_s2_reg == dhp_pkg::HA_RADDR) begin
         raddr_reg <= data_s2_reg;
      end
   end

   // -------------------------------------------------------------------
   // command decode; codes 24 to 30 still load a control register too
   // -------------------------------------------------------------------
   assign cmd_halt     = waddr_write_reg &&
                         waddr_reg == dhp_pkg::CMD_LD_HALT;
   assign cmd_restart  = waddr_write_reg &&
                         waddr_reg == dhp_pkg::CMD_LD_RESTART;
   assign cmd_snapshot = waddr_write_reg &&
                         waddr_reg == dhp_pkg::CMD_SNAPSHOT;
   assign cmd_init     = waddr_write_reg &&
                         waddr_reg == dhp_pkg::CMD_LD_INIT;

   // -------------------------------------------------------------------
   // loop filter snapshot; all three taken on the same edge
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         carrier_snap_reg <= dhp_pkg::HOLD_RESET;
         symbol_snap_reg  <= dhp_pkg::HOLD_RESET;
         gain_snap_reg    <= dhp_pkg::BYTE_RESET;
      end else if (cmd_snapshot) begin
         carrier_snap_reg <= carrier_lag_acc;
         symbol_snap_reg  <= symbol_lag_acc;
         gain_snap_reg    <= gain_acc;
      end
   end

   // -------------------------------------------------------------------
   // lock detector stop control
   // -------------------------------------------------------------------
   always_comb begin
      ld_state_next = ld_state_reg;
      unique case (ld_state_reg)
         DHP_LD_RUN: begin
            if (lock_mode_processor && lock_integ_end) begin
               ld_state_next = DHP_LD_STOPPED;
            end else if (cmd_halt && !lock_mode_processor) begin
               ld_state_next = DHP_LD_PENDING;
            end
         end
         DHP_LD_PENDING: begin
            if (cmd_restart) begin
               ld_state_next = DHP_LD_RUN;
            end else if (lock_integ_end) begin
               ld_state_next = DHP_LD_STOPPED;
            end
         end
         DHP_LD_STOPPED: begin
            if (cmd_restart || (cmd_init && lock_mode_processor)) begin
               ld_state_next = DHP_LD_RUN;
            end
         end
         default: ld_state_next = DHP_LD_RUN;
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ld_state_reg <= DHP_LD_RUN;
      end else begin
         ld_state_reg <= ld_state_next;
      end
   end

   // -------------------------------------------------------------------
   // lock detector outputs; verify counter lives in the core and is kept
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         lock_reload_enable <= 1'b1;
         lock_init          <= 1'b0;
      end else begin
         lock_reload_enable <= (ld_state_next == DHP_LD_RUN);
         lock_init          <= cmd_init;
      end
   end

   // stopped flags split by mode
   assign fsm_stop_ready_flag = ld_state_reg == DHP_LD_STOPPED &&
                                !lock_mode_processor;
   assign up_stop_ready_flag  = ld_state_reg == DHP_LD_STOPPED &&
                                lock_mode_processor;

   // -------------------------------------------------------------------
   // internal status register, refreshed every clock
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         internal_status_bits <= dhp_pkg::BYTE_RESET;
      end else begin
         internal_status_bits <= {fsm_stop_ready_flag,
                                  up_stop_ready_flag,
                                  core_status_bits};
      end
   end

   // -------------------------------------------------------------------
   // readback selection; lock values are live, so only valid once stopped
   // -------------------------------------------------------------------
   always_comb begin
      read_word = dhp_pkg::HOLD_RESET;
      unique case (raddr_reg)
         dhp_pkg::RSEL_CARRIER: read_word = carrier_snap_reg;
         dhp_pkg::RSEL_SYMBOL:  read_word = symbol_snap_reg;
         dhp_pkg::RSEL_GAIN:    read_word = {24'h000000,
                                             gain_snap_reg};
         dhp_pkg::RSEL_LOCK1:   read_word = {phase_error_acc,
                                             false_lock_acc};
         dhp_pkg::RSEL_LOCK2:   read_word = {16'h0000,
                                             gain_error_acc};
         default:               read_word = dhp_pkg::HOLD_RESET;
      endcase
   end

   // byte mux by host address
   always_comb begin
      read_byte = dhp_pkg::BYTE_RESET;
      unique case (addr_s2_reg)
         3'h0:               read_byte = read_word[7:0];
         3'h1:               read_byte = read_word[15:8];
         3'h2:               read_byte = read_word[23:16];
         3'h3:               read_byte = read_word[31:24];
         dhp_pkg::HA_STATUS: read_byte = internal_status_bits;
         default:            read_byte = dhp_pkg::BYTE_RESET;
      endcase
   end

   // -------------------------------------------------------------------
   // bus drive while the synchronised read strobe is low
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         host_data_bus_out <= dhp_pkg::BYTE_RESET;
         host_data_bus_oe  <= 1'b0;
      end else begin
         host_data_bus_oe  <= !rd_s2_reg;
         host_data_bus_out <= !rd_s2_reg ? read_byte
                                         : dhp_pkg::BYTE_RESET;
      end
   end

   // -------------------------------------------------------------------
   // carrier and loader
   // -------------------------------------------------------------------
   assign cfg.waddr_write = waddr_write_reg;
   assign cfg.waddr_value = waddr_reg;
   assign cfg.hold_bytes  = hold_reg;

   dhp_cfg_loader u_loader (
      .clk              (clk),
      .rst_n            (rst_sync_n),
      .cfg              (cfg.loader),
      .ctrl_load_strobe (ctrl_load_strobe),
      .ctrl_load_addr   (ctrl_load_addr),
      .ctrl_load_data   (ctrl_load_data)
   );
endmodule

// [rtl/dhp_pkg.sv]
// Purpose: shared constants for the demodulator host configuration port
// Assumes: 8-bit host bus, 3-bit address select, single device clock
// Notes:   command values are write address register codes
package dhp_pkg;
   // -------------------------------------------------------------------
   // host address select decode
   // -------------------------------------------------------------------
   localparam logic [2:0] HA_HOLD0  = 3'h0;
   localparam logic [2:0] HA_HOLD1  = 3'h1;
   localparam logic [2:0] HA_HOLD2  = 3'h2;
   localparam logic [2:0] HA_HOLD3  = 3'h3;
   localparam logic [2:0] HA_WADDR  = 3'h4;
   localparam logic [2:0] HA_RADDR  = 3'h5;
   localparam logic [2:0] HA_STATUS = 3'h4;
   // -------------------------------------------------------------------
   // write address register codes
   // -------------------------------------------------------------------
   localparam logic [7:0] NUM_CTRL_REGS  = 8'h20;
   localparam logic [7:0] CMD_LD_HALT    = 8'h18;
   localparam logic [7:0] CMD_LD_RESTART = 8'h19;
   localparam logic [7:0] CMD_SNAPSHOT   = 8'h1d;
   localparam logic [7:0] CMD_LD_INIT    = 8'h1e;
   // -------------------------------------------------------------------
   // read address register selections
   // -------------------------------------------------------------------
   localparam logic [7:0] RSEL_CARRIER = 8'h00;
   localparam logic [7:0] RSEL_SYMBOL  = 8'h01;
   localparam logic [7:0] RSEL_GAIN    = 8'h02;
   localparam logic [7:0] RSEL_LOCK1   = 8'h03;
   localparam logic [7:0] RSEL_LOCK2   = 8'h04;
   // -------------------------------------------------------------------
   // status bit positions, timing counts, reset values
   // -------------------------------------------------------------------
   localparam int         SR_FSM_STOP_BIT = 7;
   localparam int         SR_UP_STOP_BIT  = 6;
   localparam logic [2:0] LOAD_DELAY_CLKS = 3'h4;
   localparam int         HOLD_GUARD_CLKS = 4;
   localparam int         SNAP_WAIT_CLKS  = 6;
   localparam logic [7:0] ADDR_RESET      = 8'h00;
   localparam logic [31:0] HOLD_RESET     = 32'h0000_0000;
   localparam logic [7:0] BYTE_RESET      = 8'h00;
endpackage

// [rtl/dhp_cfg_if.sv]
// Purpose: carries write address events and holding bytes to the loader
// Assumes: same clock on both ends
// Notes:   waddr_write is a one-cycle pulse
`timescale 1ns/1ps
interface dhp_cfg_if;
   logic        waddr_write;  // write address register just written
   logic [7:0]  waddr_value;  // value now held in it
   logic [31:0] hold_bytes;   // four holding registers, byte 0 low
   // -------------------------------------------------------------------
   // modports
   // -------------------------------------------------------------------
   modport port_side (output waddr_write, output waddr_value,
                      output hold_bytes);
   modport loader (input waddr_write, input waddr_value,
                   input hold_bytes);
endinterface

// [rtl/dhp_cfg_loader.sv]
// Purpose: copies holding bytes into a control register after a delay
// Assumes: host leaves holding registers alone during the delay
// Notes:   a new address write below NUM_CTRL_REGS restarts the delay
`timescale 1ns/1ps
module dhp_cfg_loader (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // configuration carrier
   dhp_cfg_if.loader        cfg,
   // control register load port
   output      logic        ctrl_load_strobe,
   output      logic [4:0]  ctrl_load_addr,
   output      logic [31:0] ctrl_load_data
);
   logic [2:0] delay_reg;
   logic [4:0] addr_reg;

   // -------------------------------------------------------------------
   // delay counter: pulse seen one edge after the address write
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         delay_reg <= 3'h0;
         addr_reg  <= 5'h00;
      end else if (cfg.waddr_write &&
                   cfg.waddr_value < dhp_pkg::NUM_CTRL_REGS) begin
         delay_reg <= dhp_pkg::LOAD_DELAY_CLKS - 3'h1;
         addr_reg  <= cfg.waddr_value[4:0];
      end else if (delay_reg != 3'h0) begin
         delay_reg <= delay_reg - 3'h1;
      end
   end

   // -------------------------------------------------------------------
   // copy on the fourth edge; bytes never loaded simply carry old values
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_load_strobe <= 1'b0;
         ctrl_load_addr   <= 5'h00;
         ctrl_load_data   <= dhp_pkg::HOLD_RESET;
      end else begin
         ctrl_load_strobe <= (delay_reg == 3'h1);
         if (delay_reg == 3'h1) begin
            ctrl_load_addr <= addr_reg;
            ctrl_load_data <= cfg.hold_bytes;
         end
      end
   end
endmodule

// [test/dhp_host_model.sv]
// Purpose: host processor model driving the eight-bit port pins
// Assumes: pins change only at the falling clock edge
// Notes:   released data shows the inverse of its last value
`timescale 1ns/1ps
module dhp_host_model (
   // clock
   input  wire logic       clk,
   // host bus pins
   output      logic [2:0] addr,
   output      logic [7:0] wdata,
   output      logic       wr_n,
   output      logic       rd_n,
   input  wire logic [7:0] rdata,
   input  wire logic       oe
);
   // idle bus: strobes high, address parked on an unused code
   initial begin
      addr = 3'h7;
      wdata = 8'h00;
      wr_n = 1'b1;
      rd_n = 1'b1;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // strobe phases of three clocks each suit the synchroniser
   task automatic write(input logic [2:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      cyc(3);
      wr_n = 1'b0;
      cyc(3);
      wr_n = 1'b1;
      cyc(2);
      addr = 3'h7;
      wdata = ~d;
      cyc(7);
   endtask

   // oe follows the read strobe alone, not the selection, so only data is taken
   task automatic read(input logic [2:0] a, output logic [7:0] d);
      addr = a;
      cyc(1);
      rd_n = 1'b0;
      cyc(5);
      d = rdata;
      rd_n = 1'b1;
      cyc(4);
   endtask
endmodule

// [test/dhp_host_port_assertions.sv]
// Purpose: pin level checks on the host configuration port
// Assumes: one clock domain, reset active low
// Notes:   bound to the top module from the testbench file
`timescale 1ns/1ps
module dhp_host_port_assertions (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // host pins
   input wire logic [2:0]  host_addr_select,
   input wire logic [7:0]  host_data_bus_in,
   input wire logic [7:0]  host_data_bus_out,
   input wire logic        host_data_bus_oe,
   input wire logic        host_wr_n,
   input wire logic        host_rd_n,
   // core side
   input wire logic [5:0]  core_status_bits,
   input wire logic        lock_init,
   input wire logic        ctrl_load_strobe,
   input wire logic [4:0]  ctrl_load_addr,
   input wire logic [31:0] ctrl_load_data
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // valid target written, seen at the trailing strobe edge
   sequence s_waddr;
      $rose(host_wr_n) && host_addr_select == 3'h4
         && host_data_bus_in < 8'h20;
   endsequence
   // strobe held low long enough to pass the synchroniser
   sequence s_reading;
      !host_rd_n [*5];
   endsequence
   chk_load_time: assert property (
      s_waddr |-> !ctrl_load_strobe [*5] ##[1:4] ctrl_load_strobe)
      else $error("control load off its delay");
   chk_load_pulse: assert property (
      ctrl_load_strobe |=> !ctrl_load_strobe)
      else $error("control load strobe too long");
   chk_load_hold: assert property (
      !ctrl_load_strobe |-> $stable(ctrl_load_addr)
         && $stable(ctrl_load_data))
      else $error("control load outputs moved");
   chk_read_drive: assert property (
      s_reading |-> host_data_bus_oe)
      else $error("bus not driven while reading");
   chk_read_idle: assert property (
      host_rd_n [*5] |-> !host_data_bus_oe)
      else $error("bus driven while idle");
   chk_out_quiet: assert property (
      !host_data_bus_oe |-> host_data_bus_out == 8'h00)
      else $error("data out not zero while idle");
   chk_status_read: assert property (
      (!host_rd_n && host_addr_select == 3'h4
         && $stable(core_status_bits)) [*5]
      |-> host_data_bus_out[5:0] == core_status_bits)
      else $error("status byte wrong");
   chk_init_pulse: assert property (
      lock_init |=> !lock_init)
      else $error("init pulse too long");
endmodule

// [test/testbench.sv]
// Purpose: self-checking bench for the host configuration port
// Assumes: host model paces strobes well above synchroniser needs
// Notes:   rows cover ordinary loads, lock tests are hand written
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [7:0]  t;
      logic [31:0] w;
      logic [3:0]  m;
      logic [31:0] e;
   } dhp_row_t;
   // partial rows keep the bytes they skip from the row before
   dhp_row_t    rows[4] = '{'{8'h00, 32'h1234_5678, 4'hf, 32'h1234_5678},
      '{8'h1f, 32'hcafe_f00d, 4'hf, 32'hcafe_f00d},
      '{8'h07, 32'h0000_00a5, 4'h1, 32'hcafe_f0a5},
      '{8'h10, 32'h5a00_0000, 4'h8, 32'h5afe_f0a5}};
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [31:0] carrier_lag_acc, symbol_lag_acc, ctrl_load_data, e, w[5];
   logic [15:0] phase_error_acc, false_lock_acc, gain_error_acc;
   logic [7:0]  gain_acc, host_data_bus_in, host_data_bus_out, d;
   logic [5:0]  core_status_bits;
   logic [4:0]  ctrl_load_addr;
   logic [2:0]  host_addr_select;
   logic        host_data_bus_oe, host_wr_n, host_rd_n, lock_init;
   logic        lock_mode_processor, lock_integ_end, lock_reload_enable;
   logic        ctrl_load_strobe;
   int          errors = 0;
   int          compares = 0;
   int          loads = 0;
   int          inits = 0;
   int          n;

   always #2.5 clk = ~clk;

   dhp_host_port uut (
      .clk(clk), .rst_n(rst_n), .host_addr_select(host_addr_select),
      .host_data_bus_in(host_data_bus_in),
      .host_data_bus_out(host_data_bus_out),
      .host_data_bus_oe(host_data_bus_oe), .host_wr_n(host_wr_n),
      .host_rd_n(host_rd_n), .carrier_lag_acc(carrier_lag_acc),
      .symbol_lag_acc(symbol_lag_acc), .gain_acc(gain_acc),
      .phase_error_acc(phase_error_acc), .false_lock_acc(false_lock_acc),
      .gain_error_acc(gain_error_acc),
      .lock_mode_processor(lock_mode_processor),
      .lock_integ_end(lock_integ_end),
      .lock_reload_enable(lock_reload_enable), .lock_init(lock_init),
      .core_status_bits(core_status_bits),
      .ctrl_load_strobe(ctrl_load_strobe), .ctrl_load_addr(ctrl_load_addr),
      .ctrl_load_data(ctrl_load_data));
   dhp_host_model host (.clk(clk), .addr(host_addr_select),
      .wdata(host_data_bus_in), .wr_n(host_wr_n), .rd_n(host_rd_n),
      .rdata(host_data_bus_out), .oe(host_data_bus_oe));

   // count pulses so a missing or doubled one shows up
   always @(posedge clk) begin
      loads <= loads + int'(ctrl_load_strobe);
      inits <= inits + int'(lock_init);
   end

   task automatic chk(input string s, input logic [31:0] x, y);
      compares++;
      if (y !== x) begin
         errors++;
         $display("ERROR %s expected %h seen %h", s, x, y);
      end
   endtask

   task automatic pulse();
      @(negedge clk) lock_integ_end = 1'b1;
      @(negedge clk) lock_integ_end = 1'b0;
   endtask

   task automatic end_sim();
      if (errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      carrier_lag_acc = 32'h8899_aabb;
      symbol_lag_acc = 32'h1122_3344;
      gain_acc = 8'h5c;
      phase_error_acc = 16'hbeef;
      false_lock_acc = 16'h0ff1;
      gain_error_acc = 16'h7e81;
      core_status_bits = 6'h2b;
      lock_mode_processor = 1'b0;
      lock_integ_end = 1'b0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("reset", 32'h080, 32'({host_data_bus_oe, lock_reload_enable,
         lock_init, ctrl_load_strobe, ctrl_load_addr}));
      chk("reset data", 32'h0, ctrl_load_data);
      foreach (rows[i]) begin
         n = loads;
         for (int b = 0; b < 4; b++)
            if (rows[i].m[b]) host.write(3'(b), rows[i].w[8*b+:8]);
         host.write(dhp_pkg::HA_WADDR, rows[i].t);
         chk("load count", 32'(n + 1), 32'(loads));
         chk("load addr", 32'(rows[i].t), 32'(ctrl_load_addr));
         chk("load data", rows[i].e, ctrl_load_data);
      end
      n = loads;
      host.write(dhp_pkg::HA_WADDR, 8'h20);
      chk("load refused", 32'(n), 32'(loads));
      host.write(dhp_pkg::HA_WADDR, dhp_pkg::CMD_SNAPSHOT);
      w = '{carrier_lag_acc, symbol_lag_acc, {24'h0, gain_acc},
         {phase_error_acc, false_lock_acc}, {16'h0, gain_error_acc}};
      carrier_lag_acc = ~carrier_lag_acc;
      symbol_lag_acc = ~symbol_lag_acc;
      gain_acc = ~gain_acc;
      host.write(dhp_pkg::HA_WADDR, dhp_pkg::CMD_LD_HALT);
      chk("reload halted", 32'h0, 32'(lock_reload_enable));
      pulse();
      host.read(dhp_pkg::HA_STATUS, d);
      chk("status", {24'h0, 2'b10, core_status_bits}, 32'(d));
      // selection 5 is out of range and must read as zero
      for (int s = 0; s < 6; s++) begin
         host.write(dhp_pkg::HA_RADDR, 8'(s));
         for (int b = 0; b < 4; b++) begin
            host.read(3'(b), d);
            e = (s < 5) ? 32'(w[s][8*b+:8]) : 32'h0;
            chk("read", e, 32'(d));
         end
      end
      host.write(dhp_pkg::HA_WADDR, dhp_pkg::CMD_LD_RESTART);
      chk("reload run", 32'h1, 32'(lock_reload_enable));
      lock_mode_processor = 1'b1;
      pulse();
      host.read(dhp_pkg::HA_STATUS, d);
      chk("status", {24'h0, 2'b01, core_status_bits}, 32'(d));
      n = inits;
      host.write(dhp_pkg::HA_WADDR, dhp_pkg::CMD_LD_INIT);
      chk("init pulse", 32'(n + 1), 32'(inits));
      core_status_bits = 6'h14;
      host.read(dhp_pkg::HA_STATUS, d);
      chk("status", {26'h0, core_status_bits}, 32'(d));
      end_sim();
   end

   // the sequence takes about 670 clocks; this allows nearly twelve times that
   initial begin
      #40us;
      errors++;
      end_sim();
   end
endmodule

bind dhp_host_port dhp_host_port_assertions chk_i (
   .clk(clk), .rst_n(rst_n), .host_addr_select(host_addr_select),
   .host_data_bus_in(host_data_bus_in),
   .host_data_bus_out(host_data_bus_out),
   .host_data_bus_oe(host_data_bus_oe), .host_wr_n(host_wr_n),
   .host_rd_n(host_rd_n), .core_status_bits(core_status_bits),
   .lock_init(lock_init), .ctrl_load_strobe(ctrl_load_strobe),
   .ctrl_load_addr(ctrl_load_addr), .ctrl_load_data(ctrl_load_data));
